/* core/frc_read_config.sv */
`timescale 1ns/1ps
`default_nettype none
`include "frc_defines.svh"
module frc_read_config #(
    parameter bit FEATURE_XIP_FORCED = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_sck,
    input wire logic i_cs_b,
    input wire logic i_dq0,
    input wire logic i_nv_dual_b,
    input wire logic i_nv_quad_b,
    input wire logic i_addr4,
    input wire logic [7:0] i_mem_data,
    output logic o_dq1,
    output logic o_dq1_oe,
    output logic [31:0] o_mem_addr,
    output logic o_mem_req,
    output logic [3:0] o_dummy_cycles,
    output logic o_xip_active,
    output logic [1:0] o_protocol
);
    import frc_pkg::*;

    logic sck_s1, sck_s2, sck_d, cs_s1, cs_s2, dq_s1, dq_s2;
    logic nd_s1, nd_s2, nq_s1, nq_s2, strap_done_reg;
    frc_state_t state_reg;
    logic [5:0] bit_cnt_reg;
    logic [2:0] fall_cnt_reg;
    logic [31:0] sh_reg, sh_next, addr_reg;
    logic [7:0] vcfg_reg, out_reg;
    logic [3:0] dummy_eff;
    logic [5:0] addr_last;
    logic rise, fall, cs_act, last_opc, last_addr, last_dummy, last_wcfg;
    logic byte_end, data_end, load_reg;

    // Two flops on sck, chip select and dq0 before use
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            {sck_s1, sck_s2, sck_d} <= 3'h0;
            {cs_s1, cs_s2} <= 2'h3;
            {dq_s1, dq_s2} <= 2'h3;
        end else begin
            sck_s1 <= i_sck;
            sck_s2 <= sck_s1;
            sck_d <= sck_s2;
            cs_s1 <= i_cs_b;
            cs_s2 <= cs_s1;
            dq_s1 <= i_dq0;
            dq_s2 <= dq_s1;
        end
    end

    // No reset on strap flops, else the latch would see reset values
    always_ff @(posedge i_clk) begin
        nd_s1 <= i_nv_dual_b;
        nd_s2 <= nd_s1;
        nq_s1 <= i_nv_quad_b;
        nq_s2 <= nq_s1;
    end

    assign cs_act = ~cs_s2;
    assign rise = cs_act & sck_s2 & ~sck_d;
    assign fall = cs_act & ~sck_s2 & sck_d;
    assign sh_next = {sh_reg[30:0], dq_s2};
    assign dummy_eff = (vcfg_reg[`FRC_DUMMY_HI:`FRC_DUMMY_LO] ==
        `FRC_DUMMY_CODE_A || vcfg_reg[`FRC_DUMMY_HI:`FRC_DUMMY_LO] ==
        `FRC_DUMMY_CODE_B) ? `FRC_DUMMY_DEFAULT :
        vcfg_reg[`FRC_DUMMY_HI:`FRC_DUMMY_LO];
    assign addr_last = i_addr4 ? `FRC_ADDR4_LAST : `FRC_ADDR3_LAST;
    assign last_opc = rise && state_reg == FRC_ST_OPC &&
        bit_cnt_reg == `FRC_OPC_LAST;
    assign last_addr = rise && state_reg == FRC_ST_ADDR &&
        bit_cnt_reg == addr_last;
    assign last_dummy = rise && state_reg == FRC_ST_DUMMY &&
        bit_cnt_reg == {2'h0, dummy_eff} - `FRC_CNT_ONE;
    assign last_wcfg = rise && state_reg == FRC_ST_WCFG &&
        bit_cnt_reg == `FRC_OPC_LAST;
    assign byte_end = fall && fall_cnt_reg == `FRC_BYTE_LAST &&
        (state_reg == FRC_ST_DATA || state_reg == FRC_ST_RCFG);
    assign data_end = byte_end && state_reg == FRC_ST_DATA;

    function automatic logic [31:0] wrap_next(input logic [31:0] a,
                                              input logic [1:0] w);
        logic [31:0] m;
        m = `FRC_WIN16_MASK;
        unique case (w)
            `FRC_WRAP_16: m = `FRC_WIN16_MASK;
            `FRC_WRAP_32: m = `FRC_WIN32_MASK;
            `FRC_WRAP_64: m = `FRC_WIN64_MASK;
            `FRC_WRAP_SEQ: m = ~32'h0;
        endcase
        return (a & ~m) | ((a + `FRC_ADDR_ONE) & m);
    endfunction : wrap_next

    // Command sequencing; chip select high always ends the frame
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= FRC_ST_IDLE;
            bit_cnt_reg <= 6'h0;
        end else if (!cs_act) begin
            state_reg <= FRC_ST_IDLE;
            bit_cnt_reg <= 6'h0;
        end else begin
            unique case (state_reg)
                FRC_ST_IDLE: state_reg <= FRC_ST_OPC;
                FRC_ST_OPC: if (last_opc) begin
                    if (sh_next[7:0] == `FRC_OPC_FAST_READ)
                        state_reg <= FRC_ST_ADDR;
                    else if (sh_next[7:0] == `FRC_OPC_WR_VCFG)
                        state_reg <= FRC_ST_WCFG;
                    else if (sh_next[7:0] == `FRC_OPC_RD_VCFG)
                        state_reg <= FRC_ST_RCFG;
                    else
                        state_reg <= FRC_ST_SKIP;
                end
                FRC_ST_ADDR: if (last_addr) state_reg <= FRC_ST_DUMMY;
                FRC_ST_DUMMY: if (last_dummy) state_reg <= FRC_ST_DATA;
                FRC_ST_WCFG: if (last_wcfg) state_reg <= FRC_ST_SKIP;
                FRC_ST_DATA, FRC_ST_RCFG, FRC_ST_SKIP: state_reg <= state_reg;
            endcase
            if (last_opc || last_addr || last_dummy || last_wcfg)
                bit_cnt_reg <= 6'h0;
            else if (rise)
                bit_cnt_reg <= bit_cnt_reg + `FRC_CNT_ONE;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            sh_reg <= 32'h0;
        else if (rise)
            sh_reg <= sh_next;
    end

    // Reserved bit forced low on every write
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            vcfg_reg <= `FRC_VCFG_RST;
        else if (last_wcfg)
            vcfg_reg <= sh_next[7:0] & `FRC_VCFG_WMASK;
    end

    // Upper address bits stay put while wrapping
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            addr_reg <= 32'h0;
        else if (last_addr)
            addr_reg <= i_addr4 ? sh_next : {8'h00, sh_next[23:0]};
        else if (data_end)
            addr_reg <= wrap_next(addr_reg,
                vcfg_reg[`FRC_WRAP_HI:`FRC_WRAP_LO]);
    end
    assign o_mem_addr = addr_reg;

    // Memory answers one cycle after the request
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_mem_req <= 1'b0;
            load_reg <= 1'b0;
        end else begin
            o_mem_req <= last_dummy | data_end;
            load_reg <= o_mem_req;
        end
    end

    // Shift out on falling edges, MSB first
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            out_reg <= 8'h0;
            fall_cnt_reg <= 3'h0;
            o_dq1 <= 1'b0;
            o_dq1_oe <= 1'b0;
        end else begin
            if (!cs_act)
                o_dq1_oe <= 1'b0;
            else if (fall && (state_reg == FRC_ST_DATA ||
                              state_reg == FRC_ST_RCFG))
                o_dq1_oe <= 1'b1;
            if (last_opc || last_dummy)
                fall_cnt_reg <= 3'h0;
            else if (fall)
                fall_cnt_reg <= fall_cnt_reg + `FRC_FCNT_ONE;
            if (fall && (state_reg == FRC_ST_DATA ||
                         state_reg == FRC_ST_RCFG))
                o_dq1 <= out_reg[7];
            if (load_reg)
                out_reg <= i_mem_data;
            else if (last_opc || (byte_end && state_reg == FRC_ST_RCFG))
                out_reg <= vcfg_reg;
            else if (fall)
                out_reg <= {out_reg[6:0], 1'b0};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_dummy_cycles <= `FRC_DUMMY_DEFAULT;
            o_xip_active <= 1'b0;
        end else begin
            o_dummy_cycles <= dummy_eff;
            o_xip_active <= FEATURE_XIP_FORCED |
                ~vcfg_reg[`FRC_XIP_BIT];
        end
    end

    // Straps are caught once, after reset release
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_protocol <= `FRC_PROT_EXT;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            if (!nq_s2)
                o_protocol <= `FRC_PROT_QUAD;
            else if (!nd_s2)
                o_protocol <= `FRC_PROT_DUAL;
            else
                o_protocol <= `FRC_PROT_EXT;
        end
    end

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    sequence s_dummy_done;
        state_reg == FRC_ST_DUMMY ##1 state_reg == FRC_ST_DATA;
    endsequence
    sequence s_adv;
        data_end ##1 1'b1;
    endsequence

    property p_dummy_default;
        (vcfg_reg[7:4] == 4'h0 || vcfg_reg[7:4] == 4'hF) |=>
            o_dummy_cycles == 4'hA;
    endproperty
    a_dummy_default: assert property (p_dummy_default)
        else $error("default dummy count wrong");

    property p_dummy_req;
        s_dummy_done |-> o_mem_req && $past(bit_cnt_reg, 1) ==
            {2'h0, dummy_eff} - 6'h01;
    endproperty
    a_dummy_req: assert property (p_dummy_req)
        else $error("dummy length or request wrong");

    property p_xip;
        ##1 o_xip_active == (FEATURE_XIP_FORCED | ~$past(vcfg_reg[3]));
    endproperty
    a_xip: assert property (p_xip)
        else $error("execute-in-place state wrong");

    property p_wrap16;
        data_end && vcfg_reg[1:0] == 2'h0 |=>
            addr_reg[31:4] == $past(addr_reg[31:4]) &&
            addr_reg[3:0] == $past(addr_reg[3:0]) + 4'h1;
    endproperty
    a_wrap16: assert property (p_wrap16)
        else $error("16-byte wrap wrong");

    property p_wrap64;
        data_end && vcfg_reg[1:0] == 2'h2 |=>
            addr_reg[31:6] == $past(addr_reg[31:6]);
    endproperty
    a_wrap64: assert property (p_wrap64)
        else $error("64-byte wrap left window");

    property p_seq;
        data_end && vcfg_reg[1:0] == 2'h3 |->
            s_adv ##0 addr_reg == $past(addr_reg) + 32'h1;
    endproperty
    a_seq: assert property (p_seq)
        else $error("sequential read skipped");

    property p_wcfg;
        last_wcfg |=> vcfg_reg == ($past(sh_next[7:0]) & 8'hFB);
    endproperty
    a_wcfg: assert property (p_wcfg)
        else $error("config write not applied");

    property p_rsv;
        vcfg_reg[2] == 1'b0;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved bit set");

    property p_proto;
        $rose(strap_done_reg) |-> o_protocol ==
            (!$past(nq_s2) ? 2'h2 : !$past(nd_s2) ? 2'h1 : 2'h0);
    endproperty
    a_proto: assert property (p_proto)
        else $error("protocol strap wrong");
endmodule : frc_read_config
`default_nettype wire

/* shared/frc_defines.svh */
`ifndef FRC_DEFINES_SVH
`define FRC_DEFINES_SVH

`define FRC_OPC_FAST_READ 8'h0B
`define FRC_OPC_WR_VCFG 8'h81
`define FRC_OPC_RD_VCFG 8'h85

`define FRC_VCFG_RST 8'hFB
`define FRC_VCFG_WMASK 8'hFB
`define FRC_DUMMY_HI 7
`define FRC_DUMMY_LO 4
`define FRC_XIP_BIT 3
`define FRC_RSV_BIT 2
`define FRC_WRAP_HI 1
`define FRC_WRAP_LO 0

`define FRC_DUMMY_CODE_A 4'h0
`define FRC_DUMMY_CODE_B 4'hF
`define FRC_DUMMY_DEFAULT 4'hA

`define FRC_WRAP_16 2'h0
`define FRC_WRAP_32 2'h1
`define FRC_WRAP_64 2'h2
`define FRC_WRAP_SEQ 2'h3
`define FRC_WIN16_MASK 32'h0000000F
`define FRC_WIN32_MASK 32'h0000001F
`define FRC_WIN64_MASK 32'h0000003F
`define FRC_ADDR_ONE 32'h00000001

`define FRC_PROT_EXT 2'h0
`define FRC_PROT_DUAL 2'h1
`define FRC_PROT_QUAD 2'h2

`define FRC_OPC_LAST 6'h07
`define FRC_ADDR3_LAST 6'h17
`define FRC_ADDR4_LAST 6'h1F
`define FRC_BYTE_LAST 3'h7
`define FRC_CNT_ONE 6'h01
`define FRC_FCNT_ONE 3'h1

`endif

/* shared/frc_pkg.sv */
`default_nettype none
package frc_pkg;
    typedef enum logic [7:0] {
        FRC_ST_IDLE  = 8'h01,
        FRC_ST_OPC   = 8'h02,
        FRC_ST_ADDR  = 8'h04,
        FRC_ST_DUMMY = 8'h08,
        FRC_ST_DATA  = 8'h10,
        FRC_ST_WCFG  = 8'h20,
        FRC_ST_RCFG  = 8'h40,
        FRC_ST_SKIP  = 8'h80
    } frc_state_t;
endpackage : frc_pkg
`default_nettype wire

/* dv/frc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module frc_host_model #(
    parameter real HALF = 62.5
) (
    output logic o_sck,
    output logic o_cs_b,
    output logic o_dq0,
    input wire logic i_dq1
);
    // Slow link leaves room for any dummy count
    initial begin
        o_sck = 1'b0;
        o_cs_b = 1'b1;
        o_dq0 = 1'b0;
    end
    task automatic bit_x(input logic b, output logic r);
        o_dq0 = b;
        #HALF o_sck = 1'b1;
        r = i_dq1;
        #HALF o_sck = 1'b0;
    endtask : bit_x
    // Commands go MSB first, one whole byte per call
    task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], r);
            rx[i] = r;
        end
    endtask : byte_x
    // Toggling data line so stale bits cannot look valid
    task automatic dummy(input int n);
        logic r;
        repeat (n) bit_x(~o_dq0, r);
    endtask : dummy
    task automatic start();
        o_cs_b = 1'b0;
        #HALF;
    endtask : start
    // Gap covers the device's input synchronisers
    task automatic stop();
        #HALF o_cs_b = 1'b1;
        #(8 * HALF);
    endtask : stop
endmodule : frc_host_model
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_clk, i_rst_b, i_nv_dual_b, i_nv_quad_b, i_addr4;
    logic i_sck, i_cs_b, i_dq0, o_dq1, o_dq1_oe, o_mem_req, o_xip_active;
    logic [7:0] i_mem_data = 8'h00;
    logic [31:0] o_mem_addr;
    logic [3:0] o_dummy_cycles;
    logic [1:0] o_protocol;
    wire dq1_line;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    // Released line shows the inverse, never the last bit
    assign dq1_line = o_dq1_oe ? o_dq1 : ~o_dq1;
    frc_read_config frc_read_config_inst (.i_clk, .i_rst_b, .i_sck,
        .i_cs_b, .i_dq0, .i_nv_dual_b, .i_nv_quad_b, .i_addr4, .i_mem_data,
        .o_dq1, .o_dq1_oe, .o_mem_addr, .o_mem_req, .o_dummy_cycles,
        .o_xip_active, .o_protocol);
    frc_host_model frc_host_model_inst (.o_sck(i_sck), .o_cs_b(i_cs_b),
        .o_dq0(i_dq0), .i_dq1(dq1_line));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Array byte depends on both ends of the address
    always @(posedge i_clk) begin
        if (o_mem_req === 1'b1) begin
            i_mem_data <= o_mem_addr[7:0] ^ o_mem_addr[31:24] ^ 8'hA5;
        end
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic check(input string name, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", name, e, g);
            errors++;
        end
    endtask : check
    task report_and_stop();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    task automatic do_reset(input logic d, q);
        @(posedge i_clk);
        #1;
        i_nv_dual_b = d;
        i_nv_quad_b = q;
        i_addr4 = 1'b0;
        i_rst_b = 1'b0;
        repeat (10) @(posedge i_clk);
        #1;
        i_rst_b = 1'b1;
        repeat (4) @(posedge i_clk);
        #1;
    endtask : do_reset
    task automatic wr_cfg(input logic [7:0] v);
        logic [7:0] r;
        frc_host_model_inst.start();
        frc_host_model_inst.byte_x(8'h81, r);
        frc_host_model_inst.byte_x(v, r);
        frc_host_model_inst.stop();
    endtask : wr_cfg
    task automatic t_reset();
        logic [1:0] tab [4] = '{2'h2, 2'h1, 2'h2, 2'h0};
        for (int i = 0; i < 4; i++) begin
            do_reset(i[1], i[0]);
            check("protocol", 32'(tab[i]), 32'(o_protocol));
            check("dummy", 32'hA, 32'(o_dummy_cycles));
            check("xip", 32'h0, 32'(o_xip_active));
        end
    endtask : t_reset
    task automatic t_cfg();
        logic [7:0] tab [3] = '{8'h07, 8'hF4, 8'h3A};
        logic [7:0] v, r;
        logic [3:0] n;
        foreach (tab[i]) begin
            v = tab[i];
            n = (v[7:4] == 4'h0 || v[7:4] == 4'hF) ? 4'hA : v[7:4];
            wr_cfg(v);
            check("dummy", 32'(n), 32'(o_dummy_cycles));
            check("xip", {31'h0, ~v[3]}, 32'(o_xip_active));
            frc_host_model_inst.start();
            frc_host_model_inst.byte_x(8'h85, r);
            for (int k = 0; k < 2; k++) begin
                frc_host_model_inst.byte_x(8'h00, r);
                check("vcfg", 32'(v & 8'hFB), 32'(r));
            end
            check("oe", 32'h1, 32'(o_dq1_oe));
            frc_host_model_inst.stop();
        end
    endtask : t_cfg
    // Cut write and unknown opcode must leave the register alone
    task automatic t_abort();
        logic [7:0] r;
        logic b;
        wr_cfg(8'h5D);
        frc_host_model_inst.start();
        frc_host_model_inst.byte_x(8'h81, r);
        repeat (7) frc_host_model_inst.bit_x(1'b0, b);
        frc_host_model_inst.stop();
        frc_host_model_inst.start();
        frc_host_model_inst.byte_x(8'hFF, r);
        frc_host_model_inst.byte_x(8'h00, r);
        check("oe", 32'h0, 32'(o_dq1_oe));
        frc_host_model_inst.stop();
        frc_host_model_inst.start();
        frc_host_model_inst.byte_x(8'h85, r);
        frc_host_model_inst.byte_x(8'h00, r);
        check("vcfg", 32'h59, 32'(r));
        frc_host_model_inst.stop();
        check("oe", 32'h0, 32'(o_dq1_oe));
    endtask : t_abort
    task automatic t_wrap();
        logic [31:0] msk [4] = '{32'h0F, 32'h1F, 32'h3F, 32'hFFFFFFFF};
        logic [31:0] a, e;
        logic [7:0] r;
        for (int w = 0; w < 4; w++) begin
            wr_cfg({4'(2 + w), 2'h2, 2'(w)});
            check("dummy", 32'(2 + w), 32'(o_dummy_cycles));
            a = (w == 3) ? 32'h0100003E : 32'h0000003E;
            i_addr4 = (w == 3);
            frc_host_model_inst.start();
            frc_host_model_inst.byte_x(8'h0B, r);
            if (w == 3) frc_host_model_inst.byte_x(a[31:24], r);
            frc_host_model_inst.byte_x(a[23:16], r);
            frc_host_model_inst.byte_x(a[15:8], r);
            frc_host_model_inst.byte_x(a[7:0], r);
            frc_host_model_inst.dummy(2 + w);
            for (int k = 0; k < 4; k++) begin
                e = (a & ~msk[w]) | ((a + 32'(k)) & msk[w]);
                frc_host_model_inst.byte_x(8'h00, r);
                check("rd", 32'(e[7:0] ^ e[31:24] ^ 8'hA5), 32'(r));
            end
            frc_host_model_inst.stop();
        end
    endtask : t_wrap
    initial begin
        i_rst_b = 1'b0;
        i_nv_dual_b = 1'b1;
        i_nv_quad_b = 1'b1;
        i_addr4 = 1'b0;
        t_reset();
        t_cfg();
        t_abort();
        t_wrap();
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
